// file: fe_line_pkg.sv
// Constants for the 100BASE-TX line coding block.
// Assumes a single 125 MHz symbol clock shared by all stages.
package fe_line_pkg;
    localparam int          CLK_PERIOD_NS = 8;
    localparam int          SYM_BITS      = 5;
    localparam int          NIB_BITS      = 4;
    // One MII nibble lasts one code-group, i.e. five symbol cycles
    localparam int          NIB_CYCLES    = 5;
    localparam logic [2:0]  NIB_CNT_LAST  = 3'h4;
    localparam logic [2:0]  NIB_CNT_RST   = 3'h0;

    localparam logic [4:0]  CG_IDLE       = 5'h1f;
    localparam logic [4:0]  CG_J          = 5'h18;
    localparam logic [4:0]  CG_K          = 5'h11;
    localparam logic [4:0]  CG_T          = 5'h0d;
    localparam logic [4:0]  CG_R          = 5'h07;

    localparam int          LFSR_BITS     = 11;
    localparam int          LFSR_TAP_HI   = 10;
    localparam int          LFSR_TAP_LO   = 8;
    localparam logic [10:0] LFSR_RST      = 11'h7ff;

    // Signal detect: steady activity, not isolated link pulses
    localparam int          SD_GAP_NS     = 256;
    localparam int          SD_GAP_CYC    = SD_GAP_NS / CLK_PERIOD_NS;
    localparam int          SD_RUN_EDGES  = 64;

    typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} tx_state_e;
endpackage

// file: rx_line_if.sv
// Receive symbols and status passed from the decoder to the top.
// Assumes both ends run on the same symbol clock.
`timescale 1ns/1ns
interface rx_line_if;
    logic [4:0] symbol;
    logic       symbol_valid;
    logic       nrz_bit;
    logic       sig_det;

    modport dec (output symbol, output symbol_valid, output nrz_bit,
                 output sig_det);
    modport pcs (input symbol, input symbol_valid, input nrz_bit,
                 input sig_det);
endinterface

// file: rx_mlt3_decoder.sv
// Receive chain: MLT-3 to NRZI to NRZ, 5-bit symbols, signal detect.
// Assumes equalised line levels arrive as two synchronous binary inputs.
`timescale 1ns/1ns
module rx_mlt3_decoder #(
    parameter int SD_EDGES = fe_line_pkg::SD_RUN_EDGES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic line_pos,
    input  wire logic line_neg,
    rx_line_if.dec    rx
);
    // Edge and gap counters are eight bits; one edge alone proves nothing
    if (SD_EDGES < 2 || SD_EDGES > 255) begin
        $error("SD_EDGES out of range");
    end

    logic [1:0] level_r;
    logic       nrzi_r;
    logic       nrzi_d_r;
    logic [4:0] shift_r;
    logic [2:0] cnt_r;
    logic [4:0] symbol_r;
    logic       valid_r;
    logic [7:0] gap_r;
    logic [7:0] edges_r;
    logic       sd_r;

    wire  [1:0] level_now = {line_pos, line_neg};
    wire        mlt_edge  = level_now != level_r;
    wire        nrz_bit   = nrzi_r ^ nrzi_d_r;
    wire        cnt_wrap  = cnt_r == fe_line_pkg::NIB_CNT_LAST;
    wire        gap_over  = gap_r >= 8'(fe_line_pkg::SD_GAP_CYC);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_r  <= 2'h0;
            nrzi_r   <= 1'b0;
            nrzi_d_r <= 1'b0;
        end else begin
            level_r  <= level_now;
            nrzi_r   <= nrzi_r ^ mlt_edge; // RQ14
            nrzi_d_r <= nrzi_r;
        end
    end

    // Symbols are unaligned; alignment happens downstream
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_r  <= 5'h00;
            cnt_r    <= fe_line_pkg::NIB_CNT_RST;
            symbol_r <= 5'h00;
            valid_r  <= 1'b0;
        end else begin
            shift_r  <= {shift_r[3:0], nrz_bit}; // RQ16
            cnt_r    <= cnt_wrap ? fe_line_pkg::NIB_CNT_RST : cnt_r + 3'h1;
            valid_r  <= cnt_wrap; // RQ16
            if (cnt_wrap)
                symbol_r <= shift_r;
        end
    end

    // Isolated link pulses, two edges each, never build a long enough run of edges while SD_EDGES is above 2
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_r   <= 8'h00;
            edges_r <= 8'h00;
            sd_r    <= 1'b0;
        end else begin
            gap_r <= mlt_edge ? 8'h00 : (gap_over ? gap_r : gap_r + 8'h01);
            if (gap_over)
                edges_r <= 8'h00; // RQ13
            else if (mlt_edge && edges_r != 8'(SD_EDGES))
                edges_r <= edges_r + 8'h01;
            sd_r <= !gap_over && edges_r == 8'(SD_EDGES); // RQ13
        end
    end

    assign rx.symbol       = symbol_r;
    assign rx.symbol_valid = valid_r;
    assign rx.nrz_bit      = nrz_bit; // RQ15
    assign rx.sig_det      = sd_r;
endmodule

// file: fast_ethernet_line_coding.sv
// 100BASE-TX line coding: 4B/5B, scrambler, NRZI, MLT-3 and receive chain.
// Assumes MII inputs are synchronous to clk and sampled on the nibble strobe.
`timescale 1ns/1ns

// How it works
// RQ1: First two preamble nibbles go out as J 11000 then K 10001.
// RQ2: Later preamble and data nibbles use the 4B/5B table.
// RQ3: When transmit enable drops, send T 01101 then R 00111.
// RQ4: After R, send IDLE until transmit enable returns.
// RQ5: IDLE code-group is 11111.
// RQ6: Scrambler is a closed-loop 11-bit LFSR.
// RQ7: Scrambler bit XORs the serial NRZ bit.
// RQ8: Scrambler seed comes from the five address straps.
// RQ9: Scrambled stream is NRZI encoded before MLT-3.
// RQ10: NRZI split into two drive streams with alternating one events.
// RQ11: Only MLT-3 output exists; no binary output mode.
// RQ12: Receive turns the MLT-3 stream into symbols toward the MII side.
// RQ13: Signal detect stays low for link pulses alone.
// RQ14: MLT-3 receive levels decode to NRZI.
// RQ15: NRZI decodes to NRZ for the descrambler.
// RQ16: Serial bits group into 5-bit symbols for the receive PCS.
// RQ17: NRZI toggles on one, holds on zero; decoder flags level changes.
// RQ18: One bit per 125 MHz cycle; reset clears scrambler and coders.
module fast_ethernet_line_coding (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [4:0] phy_address_straps,
    input  wire logic       tx_en,
    input  wire logic [3:0] txd,
    output logic            tx_nibble_stb,
    output logic            mlt3_pos,
    output logic            mlt3_neg,
    input  wire logic       rx_line_pos,
    input  wire logic       rx_line_neg,
    output logic [4:0]      rx_symbol,
    output logic            rx_symbol_valid,
    output logic            rx_nrz,
    output logic            signal_detect
);
    function automatic logic [4:0] enc4b5b(input logic [3:0] nib);
        logic [4:0] cg;
        cg = fe_line_pkg::CG_IDLE;
        unique case (nib)
            4'h0: cg = 5'h1e;
            4'h1: cg = 5'h09;
            4'h2: cg = 5'h14;
            4'h3: cg = 5'h15;
            4'h4: cg = 5'h0a;
            4'h5: cg = 5'h0b;
            4'h6: cg = 5'h0e;
            4'h7: cg = 5'h0f;
            4'h8: cg = 5'h12;
            4'h9: cg = 5'h13;
            4'ha: cg = 5'h16;
            4'hb: cg = 5'h17;
            4'hc: cg = 5'h1a;
            4'hd: cg = 5'h1b;
            4'he: cg = 5'h1c;
            4'hf: cg = 5'h1d;
        endcase
        return cg;
    endfunction

    fe_line_pkg::tx_state_e state_r;
    fe_line_pkg::tx_state_e state_nxt;
    logic [4:0]             cg_nxt;
    logic [2:0]             nib_cnt_r;
    logic [4:0]             shift_r;
    logic [10:0]            lfsr_r;
    logic                   seed_pend_r;
    logic                   nrzi_r;
    logic                   nrzi_d_r;
    logic [1:0]             phase_r;
    logic                   pos_r;
    logic                   neg_r;

    // Nibble rate enable: one code-group per five symbol cycles
    wire nib_stb = nib_cnt_r == fe_line_pkg::NIB_CNT_LAST;

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            nib_cnt_r <= fe_line_pkg::NIB_CNT_RST;
        else
            nib_cnt_r <= nib_stb ? fe_line_pkg::NIB_CNT_RST
                                 : nib_cnt_r + 3'h1;
    end

    always_comb begin
        state_nxt = state_r;
        cg_nxt    = fe_line_pkg::CG_IDLE; // RQ5
        unique case (state_r)
            fe_line_pkg::TX_IDLE: begin
                if (tx_en) begin
                    cg_nxt    = fe_line_pkg::CG_J; // RQ1
                    state_nxt = fe_line_pkg::TX_K;
                end else begin
                    cg_nxt    = fe_line_pkg::CG_IDLE; // RQ4
                end
            end
            fe_line_pkg::TX_K: begin
                cg_nxt    = fe_line_pkg::CG_K; // RQ1
                state_nxt = fe_line_pkg::TX_DATA;
            end
            fe_line_pkg::TX_DATA: begin
                if (tx_en) begin
                    cg_nxt    = enc4b5b(txd); // RQ2
                end else begin
                    cg_nxt    = fe_line_pkg::CG_T; // RQ3
                    state_nxt = fe_line_pkg::TX_R;
                end
            end
            fe_line_pkg::TX_R: begin
                cg_nxt    = fe_line_pkg::CG_R; // RQ3
                state_nxt = fe_line_pkg::TX_IDLE;
            end
        endcase
    end

    // Code-groups leave MSB first, one bit per symbol clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= fe_line_pkg::TX_IDLE;
            shift_r <= fe_line_pkg::CG_IDLE; // RQ18
        end else if (nib_stb) begin
            state_r <= state_nxt;
            shift_r <= cg_nxt;
        end else begin
            shift_r <= {shift_r[3:0], 1'b1}; // RQ18
        end
    end

    // Straps are caught one cycle after reset release, never by reset
    wire [10:0] strap_seed = {phy_address_straps, ~phy_address_straps,
                              1'b1};
    wire        lfsr_fb    = lfsr_r[fe_line_pkg::LFSR_TAP_HI]
                           ^ lfsr_r[fe_line_pkg::LFSR_TAP_LO];
    wire        nrz_bit    = shift_r[4];
    wire        scr_bit    = nrz_bit ^ lfsr_fb; // RQ7

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lfsr_r      <= fe_line_pkg::LFSR_RST; // RQ18
            seed_pend_r <= 1'b1;
        end else if (seed_pend_r) begin
            lfsr_r      <= strap_seed; // RQ8
            seed_pend_r <= 1'b0;
        end else begin
            lfsr_r      <= {lfsr_r[9:0], lfsr_fb}; // RQ6
        end
    end

    // MLT-3 phase steps on every NRZI transition: 0, +, 0, -
    wire       nrzi_edge = nrzi_r != nrzi_d_r;
    wire [1:0] phase_nxt = nrzi_edge ? phase_r + 2'h1 : phase_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nrzi_r   <= 1'b0;
            nrzi_d_r <= 1'b0;
            phase_r  <= 2'h0;
            pos_r    <= 1'b0;
            neg_r    <= 1'b0;
        end else begin
            nrzi_r   <= nrzi_r ^ scr_bit; // RQ9 RQ17
            nrzi_d_r <= nrzi_r;
            phase_r  <= phase_nxt;
            pos_r    <= phase_nxt == 2'h1; // RQ10
            neg_r    <= phase_nxt == 2'h3; // RQ10
        end
    end

    // No bypass path: the line only ever sees the MLT-3 pair
    assign mlt3_pos      = pos_r; // RQ11
    assign mlt3_neg      = neg_r; // RQ11
    assign tx_nibble_stb = nib_stb;

    rx_line_if rx_bus ();

    rx_mlt3_decoder #(
        .SD_EDGES (fe_line_pkg::SD_RUN_EDGES)
    ) u_rx (
        .clk      (clk),
        .rst      (rst),
        .line_pos (rx_line_pos),
        .line_neg (rx_line_neg),
        .rx       (rx_bus.dec)
    );

    // Nibble conversion lives past the descrambler and aligner
    assign rx_symbol       = rx_bus.symbol; // RQ12
    assign rx_symbol_valid = rx_bus.symbol_valid;
    assign rx_nrz          = rx_bus.nrz_bit;
    assign signal_detect   = rx_bus.sig_det;
endmodule

// file: fe_line_sva.sv
// Checker on the line coding top: MLT-3 pins, strobes, receive chain.
// Assumes one clock domain and sees the top module's ports only.
`timescale 1ns/1ns
module fe_line_sva (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       tx_nibble_stb,
    input wire logic       mlt3_pos,
    input wire logic       mlt3_neg,
    input wire logic       rx_line_pos,
    input wire logic       rx_line_neg,
    input wire logic [4:0] rx_symbol,
    input wire logic       rx_symbol_valid,
    input wire logic       rx_nrz,
    input wire logic       signal_detect
);
    logic       last_pos_r;
    logic [1:0] lvl_r;
    logic [7:0] gap_r;
    wire        chg = {rx_line_pos, rx_line_neg} != lvl_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_pos_r <= 1'b0;
            lvl_r      <= 2'h0;
            gap_r      <= 8'h00;
        end else begin
            if (mlt3_pos || mlt3_neg) last_pos_r <= mlt3_pos;
            lvl_r <= {rx_line_pos, rx_line_neg};
            gap_r <= chg ? 8'h00 : gap_r + {7'h00, gap_r != 8'hff};
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    chk_pins_exclusive: assert property (!(mlt3_pos && mlt3_neg))
        else $error("both line pins high");
    chk_pos_after_neg: assert property (
        $rose(mlt3_pos) |-> !last_pos_r)
        else $error("positive level twice in a row");
    chk_neg_after_pos: assert property ($rose(mlt3_neg) |-> last_pos_r)
        else $error("negative level twice in a row");
    chk_zero_between: assert property (
        $rose(mlt3_pos) || $rose(mlt3_neg) |-> $past(!mlt3_pos && !mlt3_neg))
        else $error("line skipped the zero level");
    chk_strobe_period: assert property (
        tx_nibble_stb |=> !tx_nibble_stb [*4] ##1 tx_nibble_stb)
        else $error("nibble strobe not every five cycles");
    chk_symbol_period: assert property (
        rx_symbol_valid |=> !rx_symbol_valid [*4] ##1 rx_symbol_valid)
        else $error("symbol valid not every five cycles");
    chk_symbol_hold: assert property (
        !rx_symbol_valid |-> $stable(rx_symbol))
        else $error("symbol changed without valid");
    chk_nrz_decode: assert property (
        !$past(rst) && !$past(rst, 2) |-> rx_nrz ==
        ({$past(rx_line_pos), $past(rx_line_neg)} !=
         {$past(rx_line_pos, 2), $past(rx_line_neg, 2)}))
        else $error("decoded bit does not follow level change");
    chk_detect_gap: assert property (gap_r > 8'h28 |-> !signal_detect)
        else $error("signal detect held across a quiet gap");
endmodule

// file: mac_model.sv
// Behavioural MAC on the transmit nibble interface.
// Assumes the block samples tx_en and txd at edges with the strobe high.
`timescale 1ns/1ns
module mac_model (
    input  wire logic  clk,
    input  wire logic  stb,
    output logic       tx_en,
    output logic [3:0] txd
);
    logic [4:0] q[$];

    initial begin
        tx_en = 1'b0;
        txd   = 4'h0;
    end

    task automatic send(input logic [4:0] n);
        q.push_back(n);
    endtask

    // Next nibble goes up just after the strobe edge that took the last
    always @(posedge clk) begin
        if (stb && q.size() > 0) begin
            {tx_en, txd} <= q.pop_front();
        end else if (stb) begin
            tx_en <= 1'b0;
            txd   <= ~txd; // Unused nibble lines do not hold old data
        end
    end
endmodule

// file: tb_top.sv
// Testbench: MAC model on transmit, MLT-3 pins looped to the receiver.
// Assumes the scrambler state can be learnt from idle on the line.
`timescale 1ns/1ns
module tb_top;
    localparam logic [4:0] cg_tab [16] = '{5'h1e, 5'h09, 5'h14, 5'h15,
        5'h0a, 5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a,
        5'h1b, 5'h1c, 5'h1d};
    logic        clk;
    logic        rst;
    logic [4:0]  straps;
    logic        tx_en;
    logic [3:0]  txd;
    logic        stb;
    logic        mp;
    logic        mn;
    logic        loop;
    logic        pp;
    logic        pn;
    logic [4:0]  rx_symbol;
    logic        rx_valid;
    logic        rx_nrz;
    logic        sd;
    logic [1:0]  lv_q;
    logic [10:0] h;
    logic        s_b;
    logic        f_b;
    logic        rec[$];
    logic [4:0]  exp_q[$];
    int          n_obs;
    int          err_total;
    int          n_checks;
    wire         rx_p = loop ? mp : pp;
    wire         rx_n = loop ? mn : pn;

    mac_model mac_u (.clk(clk), .stb(stb), .tx_en(tx_en), .txd(txd));
    fast_ethernet_line_coding dut_u (.clk(clk), .rst(rst),
        .phy_address_straps(straps), .tx_en(tx_en), .txd(txd),
        .tx_nibble_stb(stb), .mlt3_pos(mp), .mlt3_neg(mn),
        .rx_line_pos(rx_p), .rx_line_neg(rx_n), .rx_symbol(rx_symbol),
        .rx_symbol_valid(rx_valid), .rx_nrz(rx_nrz),
        .signal_detect(sd));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Line changes give scrambled bits; idle (all ones) teaches the LFSR
    always @(posedge clk) begin
        s_b = {mp, mn} != lv_q;
        f_b = n_obs < 30 ? ~s_b : h[10] ^ h[8];
        lv_q <= {mp, mn};
        h <= {h[9:0], f_b};
        n_obs <= rst ? 0 : n_obs + 1;
        if (n_obs >= 30) rec.push_back(s_b ^ f_b);
    end

    function automatic logic [4:0] grp(input int p);
        return {rec[p], rec[p+1], rec[p+2], rec[p+3], rec[p+4]};
    endfunction

    task automatic check(input string nm, input logic [15:0] got,
                         input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic give_up(input logic hit);
        if (hit) begin
            err_total++;
            $display("FAIL wait expired");
            tally_and_finish();
        end
    endtask

    task automatic do_reset(input logic [4:0] s);
        @(posedge clk);
        rst    <= 1'b1;
        straps <= s;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
    endtask

    // Two frames with a minimal gap: T, R, then J at the very next strobe
    task automatic t_frames();
        int i;
        int k;
        loop <= 1'b1;
        repeat (60) @(posedge clk);
        @(negedge clk);
        rec.delete();
        exp_q = {fe_line_pkg::CG_IDLE, fe_line_pkg::CG_J, fe_line_pkg::CG_K};
        for (i = 0; i < 16; i++) exp_q.push_back(cg_tab[i]);
        exp_q = {exp_q, fe_line_pkg::CG_T, fe_line_pkg::CG_R,
                 fe_line_pkg::CG_J, fe_line_pkg::CG_K, cg_tab[7],
                 fe_line_pkg::CG_T, fe_line_pkg::CG_R};
        repeat (6) exp_q.push_back(fe_line_pkg::CG_IDLE);
        mac_u.send(5'h15);
        mac_u.send(5'h15);
        for (i = 0; i < 16; i++) mac_u.send({1'b1, i[3:0]});
        mac_u.send(5'h00);
        mac_u.send(5'h00);
        mac_u.send(5'h15);
        mac_u.send(5'h15);
        mac_u.send(5'h17);
        for (i = 0; i < 400 && mac_u.q.size() > 0; i++) @(posedge clk);
        give_up(i == 400);
        repeat (120) @(posedge clk);
        k = -10;
        for (i = 5; i < rec.size() && k < 0; i++)
            if (grp(i) == fe_line_pkg::CG_J && rec[i+5] == 1'b1) k = i;
        foreach (exp_q[j])
            check("code_group", grp(k - 5 + 5 * j), exp_q[j]);
        $display("frames done");
    endtask

    task automatic t_loop();
        int         i;
        logic [5:0] eb;
        logic [1:0] p1;
        logic [1:0] p2;
        logic       e;
        for (i = 0; i < 1000 && sd !== 1'b1; i++) @(posedge clk);
        give_up(i == 1000);
        check("detect_on_traffic", sd, 1'b1);
        // Received bits follow line level changes one cycle later
        @(posedge clk);
        p2 = {mp, mn};
        @(posedge clk);
        p1 = {mp, mn};
        eb = 6'h00;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            e = p1 != p2;
            check("rx_nrz", rx_nrz, e);
            if (rx_valid && i >= 6)
                check("rx_symbol", rx_symbol, eb[5:1]);
            eb = {eb[4:0], e};
            p2 = p1;
            p1 = {mp, mn};
        end
        loop <= 1'b0;
        repeat (60) @(posedge clk);
        check("detect_after_gap", sd, 1'b0);
        $display("loopback done");
    endtask

    // Isolated one-cycle pulses, far apart, as link pulses would be
    task automatic t_pulses();
        logic seen;
        logic alt;
        seen = 1'b0;
        alt  = 1'b0;
        repeat (80) begin
            @(posedge clk);
            pp <= !alt;
            pn <= alt;
            @(posedge clk);
            pp <= 1'b0;
            pn <= 1'b0;
            alt = !alt;
            repeat (48) @(posedge clk) seen = seen | sd;
        end
        check("detect_on_pulses", seen, 1'b0);
        $display("pulses done");
    endtask

    task automatic t_seed();
        logic [10:0] a;
        logic [10:0] b;
        do_reset(5'h0a);
        repeat (60) @(posedge clk);
        @(negedge clk);
        a = h;
        do_reset(5'h15);
        repeat (60) @(posedge clk);
        @(negedge clk);
        b = h;
        check("seed_differs", a == b, 1'b0);
        do_reset(5'h0a);
        repeat (60) @(posedge clk);
        @(negedge clk);
        check("seed_repeat", h, a);
        $display("seed done");
    endtask

    initial begin
        rst = 1'b1;
        straps = 5'h0a;
        loop = 1'b0;
        pp = 1'b0;
        pn = 1'b0;
        n_obs = 0;
        err_total = 0;
        n_checks = 0;
        do_reset(5'h0a);
        t_frames();
        t_loop();
        t_pulses();
        t_seed();
        tally_and_finish();
    end
endmodule

bind fast_ethernet_line_coding fe_line_sva chk_u (.clk(clk), .rst(rst),
    .tx_nibble_stb(tx_nibble_stb), .mlt3_pos(mlt3_pos),
    .mlt3_neg(mlt3_neg), .rx_line_pos(rx_line_pos),
    .rx_line_neg(rx_line_neg), .rx_symbol(rx_symbol),
    .rx_symbol_valid(rx_symbol_valid), .rx_nrz(rx_nrz),
    .signal_detect(signal_detect));
